// [rtl/core_map_consts.vh]
// Constants for the core memory map and special registers
`ifndef CORE_MAP_CONSTS_VH
`define CORE_MAP_CONSTS_VH
`define SFR_STACK_LOW 8'h81
`define SFR_POWER_CTRL 8'h87
`define SFR_WAIT_COUNT 8'h9f
`define SFR_CONFIG 8'haf
`define SFR_STACK_HIGH 8'hb7
`define SFR_STATUS 8'hd0
`define SFR_PTR_LOW 8'h82
`define SFR_PTR_HIGH 8'h83
`define SFR_PTR_PAGE 8'h84
`define RST_STACK_LOW 8'h07
`define RST_ZERO 8'h00
`define SFR_SPACE_BASE 8'h80
`define BIT_AREA_BASE 8'h20
`define XRAM_TOP 24'h0007ff
`define STACK_XRAM_BASE 11'h100
`define MOVX_BASE_CYCLES 4'h4
`define WAIT_MAX 3'h7
`define CFG_STACK_EXT_BIT 7
`define CFG_XRAM_MAP_BIT 0
`define PC_BAUD_DOUBLE_BIT 7
`define PC_SERIAL_WAKE_BIT 6
`define PC_IRQ0_WAKE_BIT 5
`define PC_LATCH_OFF_BIT 4
`define PC_SLEEP_BIT 1
`define PC_IMPL_MASK 8'hfe
`define CFG_IMPL_MASK 8'h81
`define PROG_SIZE 17'h0f800
`define PROG_WRITABLE_TOP 16'hdfff
`endif

// [rtl/core_memory_map_sfrs.v]
// Core memory map: internal RAM, special registers, stack, data pointer
// Functional notes
// - External-access high: fetch internal code below 0F800H
// - Lower program memory writable during run time
// - Upper RAM indirect only; direct hits registers
// - Lowest 32 bytes form four register banks
// - Bit addresses 00-7F map bytes 20-2F
// - Stack pointer resets to 07H
// - Push pre-increments stack pointer before writing
// - Map enable puts XRAM at bottom
// - Pointer above 0007FFH always goes off chip
// - Internal XRAM access leaves bus pins idle
// - Stack wraps FFH->00H, or extends to 0100H
// - Eleven-bit stack from low byte plus three
// - High stack byte dead unless extend set
// - Auto strobes, 24-bit external data address
// - Wait count 0-7 gives 4+n cycles
// - Pointer bytes separate; increment carries into page
// - Status word layout, resets to zero
// - Two status bits select active bank
// - Power control resets zero; baud, flags
// - Sleep bit enters power-down
// - Serial wake bit lets serial interrupt wake
// - Interrupt-zero wake by level or edge
// - Latch strobe disable bit kills strobe
// - Config resets zero; bit7 stack, bit0 map
`timescale 1ns/1ps
`default_nettype none
`include "core_map_consts.vh"
module core_memory_map_sfrs #(
    parameter PROG_AW = 16,
    parameter XRAM_AW = 11
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_ext_access_pin,
    // Direct and indirect data space access
    input wire i_dir_wr,
    input wire i_dir_rd,
    input wire i_ind_wr,
    input wire i_ind_rd,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    // Working register and bit access
    input wire i_reg_wr,
    input wire [2:0] i_reg_num,
    input wire i_bit_wr,
    input wire i_bit_rd,
    input wire [7:0] i_bit_addr,
    input wire i_bit_val,
    // Stack operations
    input wire i_push,
    input wire i_pop,
    input wire [7:0] i_stack_wdata,
    // Pointer increment and flag updates from the core
    input wire i_ptr_inc,
    input wire i_flag_wr,
    input wire [7:0] i_flag_val,
    // Program memory
    input wire [PROG_AW-1:0] i_fetch_addr,
    input wire i_prog_wr,
    input wire [PROG_AW-1:0] i_prog_waddr,
    input wire [7:0] i_prog_wdata,
    output reg o_fetch_internal,
    output reg o_prog_wr_ok,
    // Data moves to the external or internal data space
    input wire i_movx_rd,
    input wire i_movx_wr,
    input wire [7:0] i_movx_wdata,
    input wire [7:0] i_ext_rdata,
    output reg [23:0] o_ext_addr,
    output reg [7:0] o_ext_wdata,
    output reg o_ext_bus_en,
    output reg o_ext_rd_n,
    output reg o_ext_wr_n,
    output reg o_latch_strobe,
    output reg [7:0] o_movx_rdata,
    output reg o_movx_done,
    output reg o_movx_busy,
    // Power and miscellaneous
    input wire i_serial_irq,
    input wire i_irq0_n,
    input wire i_irq0_edge_sel,
    output reg o_power_down,
    output reg o_baud_doubler,
    output reg [1:0] o_bank_sel,
    output reg [10:0] o_stack_ptr
);
    reg [7:0] ram_mem [0:255];
    reg [7:0] xram_mem [0:(1<<XRAM_AW)-1];
    reg [7:0] stack_ptr_low_reg;
    reg [2:0] stack_ptr_high_reg;
    reg [7:0] power_control_reg;
    reg [2:0] movx_wait_count_reg;
    reg [7:0] config_reg;
    reg [7:0] program_status_word_reg;
    reg [7:0] pointer_low_byte_reg;
    reg [7:0] pointer_high_byte_reg;
    reg [7:0] pointer_page_byte_reg;
    reg [10:0] sp_next;
    reg [3:0] movx_cnt_reg;
    reg movx_int_reg;
    reg movx_rd_reg;
    reg irq0_s1_reg;
    reg irq0_s2_reg;
    reg irq0_prev_reg;
    reg ext_boot_reg;
    reg rst_seen_reg;
    reg boot_s1_reg;
    reg boot_s2_reg;
    wire stack_ext;
    wire xram_map;
    wire [23:0] data_pointer;
    wire movx_internal;
    wire [7:0] bank_base;
    wire irq0_wake;
    reg [7:0] sfr_rdata;

    // Bank and bit address decode
    function [7:0] bit_byte;
        input [7:0] baddr;
        begin
            bit_byte = `BIT_AREA_BASE + {4'h0, baddr[6:3]};
        end
    endfunction

    assign stack_ext = config_reg[`CFG_STACK_EXT_BIT];
    assign xram_map = config_reg[`CFG_XRAM_MAP_BIT];
    assign data_pointer = {pointer_page_byte_reg, pointer_high_byte_reg,
        pointer_low_byte_reg};
    assign movx_internal = xram_map && (data_pointer <= `XRAM_TOP);
    assign bank_base = {3'h0, program_status_word_reg[4:3], 3'h0};
    assign irq0_wake = i_irq0_edge_sel ? (irq0_prev_reg && !irq0_s2_reg)
        : !irq0_s2_reg;

    // Next stack pointer on push or pop
    always @* begin
        sp_next = {stack_ptr_high_reg, stack_ptr_low_reg};
        if (i_push) begin
            sp_next = sp_next + 11'h001;
        end else if (i_pop) begin
            sp_next = sp_next - 11'h001;
        end
        if (!stack_ext) begin
            sp_next[10:8] = 3'h0;
        end
    end

    // Register read mux
    always @* begin
        case (i_addr)
            `SFR_STACK_LOW: sfr_rdata = stack_ptr_low_reg;
            `SFR_POWER_CTRL: sfr_rdata = power_control_reg;
            `SFR_WAIT_COUNT: sfr_rdata = {5'h00, movx_wait_count_reg};
            `SFR_CONFIG: sfr_rdata = config_reg;
            `SFR_STACK_HIGH: sfr_rdata = stack_ext ?
                {5'h00, stack_ptr_high_reg} : 8'h00;
            `SFR_STATUS: sfr_rdata = program_status_word_reg;
            `SFR_PTR_LOW: sfr_rdata = pointer_low_byte_reg;
            `SFR_PTR_HIGH: sfr_rdata = pointer_high_byte_reg;
            `SFR_PTR_PAGE: sfr_rdata = pointer_page_byte_reg;
            default: sfr_rdata = 8'h00;
        endcase
    end

    // Interrupt-zero pin synchroniser
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq0_s1_reg <= 1'b1;
            irq0_s2_reg <= 1'b1;
            irq0_prev_reg <= 1'b1;
        end else begin
            irq0_s1_reg <= i_irq0_n;
            irq0_s2_reg <= irq0_s1_reg;
            irq0_prev_reg <= irq0_s2_reg;
        end
    end

    // Strap pin synchroniser, free running so it is settled at release
    always @(posedge i_clk) begin
        boot_s1_reg <= i_ext_access_pin;
        boot_s2_reg <= boot_s1_reg;
    end

    // Boot strap caught after reset release
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ext_boot_reg <= 1'b0;
            rst_seen_reg <= 1'b0;
        end else if (!rst_seen_reg) begin
            ext_boot_reg <= boot_s2_reg;
            rst_seen_reg <= 1'b1;
        end
    end

    // Program memory fetch and write permission
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_fetch_internal <= 1'b0;
            o_prog_wr_ok <= 1'b0;
        end else begin
            // Internal below the top only, no rollover past the top
            o_fetch_internal <= ext_boot_reg &&
                ({1'b0, i_fetch_addr} < `PROG_SIZE);
            o_prog_wr_ok <= i_prog_wr &&
                (i_prog_waddr <= `PROG_WRITABLE_TOP);
        end
    end

    // Special registers
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stack_ptr_low_reg <= `RST_STACK_LOW;
            stack_ptr_high_reg <= 3'h0;
            power_control_reg <= `RST_ZERO;
            movx_wait_count_reg <= 3'h0;
            config_reg <= `RST_ZERO;
            program_status_word_reg <= `RST_ZERO;
            pointer_low_byte_reg <= 8'h00;
            pointer_high_byte_reg <= 8'h00;
            pointer_page_byte_reg <= 8'h00;
        end else begin
            if (i_push || i_pop) begin
                {stack_ptr_high_reg, stack_ptr_low_reg} <= sp_next;
            end
            if (i_ptr_inc) begin
                // Carry runs from the high byte into the page
                {pointer_page_byte_reg, pointer_high_byte_reg,
                    pointer_low_byte_reg} <= data_pointer + 24'h000001;
            end
            if (i_flag_wr) begin
                program_status_word_reg <= i_flag_val;
            end
            if (i_bit_wr && i_bit_addr == `SFR_STATUS + {5'h00,
                i_bit_addr[2:0]}) begin
                program_status_word_reg[i_bit_addr[2:0]] <= i_bit_val;
            end
            if (o_power_down && ((power_control_reg[`PC_SERIAL_WAKE_BIT] &&
                i_serial_irq) || (power_control_reg[`PC_IRQ0_WAKE_BIT] &&
                irq0_wake))) begin
                power_control_reg[`PC_SLEEP_BIT] <= 1'b0;
            end
            if (i_dir_wr && i_addr >= `SFR_SPACE_BASE) begin
                case (i_addr)
                    `SFR_STACK_LOW: stack_ptr_low_reg <= i_wdata;
                    `SFR_POWER_CTRL: power_control_reg <= i_wdata &
                        `PC_IMPL_MASK;
                    `SFR_WAIT_COUNT: movx_wait_count_reg <= i_wdata[2:0];
                    `SFR_CONFIG: config_reg <= i_wdata & `CFG_IMPL_MASK;
                    `SFR_STACK_HIGH: begin
                        if (stack_ext) begin
                            stack_ptr_high_reg <= i_wdata[2:0];
                        end
                    end
                    `SFR_STATUS: program_status_word_reg <= i_wdata;
                    `SFR_PTR_LOW: pointer_low_byte_reg <= i_wdata;
                    `SFR_PTR_HIGH: pointer_high_byte_reg <= i_wdata;
                    `SFR_PTR_PAGE: pointer_page_byte_reg <= i_wdata;
                    default: ;
                endcase
            end
        end
    end

    // Internal RAM, working registers, bit area and stack writes
    always @(posedge i_clk) begin
        if ((i_dir_wr && i_addr < `SFR_SPACE_BASE) || i_ind_wr) begin
            ram_mem[i_addr] <= i_wdata;
        end
        if (i_reg_wr) begin
            ram_mem[bank_base + {5'h00, i_reg_num}] <= i_wdata;
        end
        if (i_bit_wr && !i_bit_addr[7]) begin
            ram_mem[bit_byte(i_bit_addr)][i_bit_addr[2:0]] <= i_bit_val;
        end
        if (i_push && sp_next[10:8] == 3'h0) begin
            ram_mem[sp_next[7:0]] <= i_stack_wdata;
        end
    end

    // Read data for the direct, indirect and bit ports
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_bit_rd) begin
            o_rdata <= {7'h00, i_bit_addr[7] ? program_status_word_reg[
                i_bit_addr[2:0]] : ram_mem[bit_byte(i_bit_addr)][
                i_bit_addr[2:0]]};
        end else if (i_dir_rd) begin
            o_rdata <= (i_addr >= `SFR_SPACE_BASE) ? sfr_rdata
                : ram_mem[i_addr];
        end else if (i_ind_rd) begin
            o_rdata <= ram_mem[i_addr];
        end
    end

    // Internal XRAM, also holding the extended stack
    always @(posedge i_clk) begin
        if (i_push && sp_next[10:8] != 3'h0) begin
            xram_mem[sp_next[XRAM_AW-1:0]] <= i_stack_wdata;
        end
        if (i_movx_wr && !o_movx_busy && movx_internal) begin
            xram_mem[data_pointer[XRAM_AW-1:0]] <= i_movx_wdata;
        end
    end

    // Data move sequencer: 4 + wait cycles
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            movx_cnt_reg <= 4'h0;
            movx_int_reg <= 1'b0;
            movx_rd_reg <= 1'b0;
            o_movx_busy <= 1'b0;
            o_movx_done <= 1'b0;
            o_movx_rdata <= 8'h00;
            o_ext_addr <= 24'h000000;
            o_ext_wdata <= 8'h00;
            o_ext_bus_en <= 1'b0;
            o_ext_rd_n <= 1'b1;
            o_ext_wr_n <= 1'b1;
        end else begin
            o_movx_done <= 1'b0;
            if (!o_movx_busy && (i_movx_rd || i_movx_wr)) begin
                o_movx_busy <= 1'b1;
                movx_cnt_reg <= `MOVX_BASE_CYCLES - 4'h1 +
                    {1'b0, movx_wait_count_reg};
                movx_int_reg <= movx_internal;
                movx_rd_reg <= i_movx_rd;
                if (movx_internal) begin
                    o_movx_rdata <= xram_mem[data_pointer[XRAM_AW-1:0]];
                end else begin
                    o_ext_addr <= data_pointer;
                    o_ext_wdata <= i_movx_wdata;
                    o_ext_bus_en <= 1'b1;
                    o_ext_rd_n <= !i_movx_rd;
                    o_ext_wr_n <= i_movx_rd;
                end
            end else if (o_movx_busy) begin
                if (movx_cnt_reg == 4'h1) begin
                    o_movx_busy <= 1'b0;
                    o_movx_done <= 1'b1;
                    o_ext_bus_en <= 1'b0;
                    o_ext_rd_n <= 1'b1;
                    o_ext_wr_n <= 1'b1;
                    if (!movx_int_reg && movx_rd_reg) begin
                        o_movx_rdata <= i_ext_rdata;
                    end
                end
                movx_cnt_reg <= movx_cnt_reg - 4'h1;
            end
        end
    end

    // Status outputs and the address latch strobe
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_latch_strobe <= 1'b0;
            o_power_down <= 1'b0;
            o_baud_doubler <= 1'b0;
            o_bank_sel <= 2'h0;
            o_stack_ptr <= {3'h0, `RST_STACK_LOW};
        end else begin
            // Strobe on the first external cycle only
            o_latch_strobe <= !power_control_reg[`PC_LATCH_OFF_BIT] &&
                !o_movx_busy && (i_movx_rd || i_movx_wr) &&
                !movx_internal;
            o_power_down <= power_control_reg[`PC_SLEEP_BIT];
            o_baud_doubler <= power_control_reg[`PC_BAUD_DOUBLE_BIT];
            o_bank_sel <= program_status_word_reg[4:3];
            o_stack_ptr <= {stack_ptr_high_reg, stack_ptr_low_reg};
        end
    end
endmodule // core_memory_map_sfrs
`default_nettype wire

// [tb/core_map_sva.sv]
// Checker for the core memory map block
`timescale 1ns/1ps
`default_nettype none
module core_map_sva #(
    parameter PROG_AW = 16
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_dir_wr,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_push,
    input wire i_pop,
    input wire i_movx_rd,
    input wire i_movx_wr,
    input wire [PROG_AW-1:0] i_fetch_addr,
    input wire i_prog_wr,
    input wire [PROG_AW-1:0] i_prog_waddr,
    input wire o_fetch_internal,
    input wire o_prog_wr_ok,
    input wire o_ext_bus_en,
    input wire o_ext_rd_n,
    input wire o_ext_wr_n,
    input wire o_latch_strobe,
    input wire o_movx_done,
    input wire o_movx_busy,
    input wire o_power_down,
    input wire o_baud_doubler,
    input wire [10:0] o_stack_ptr
);
    reg [2:0] wait_reg;
    reg ext_reg;
    reg alo_reg;
    reg [3:0] cnt_reg;
    // Shadow of wait count and latch disable; stack extend flag sticks once set
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_reg <= 3'h0;
            ext_reg <= 1'h0;
            alo_reg <= 1'h0;
        end else if (i_dir_wr) begin
            if (i_addr == 8'h9f) wait_reg <= i_wdata[2:0];
            if (i_addr == 8'haf && i_wdata[7]) ext_reg <= 1'h1;
            if (i_addr == 8'h87) alo_reg <= i_wdata[4];
        end
    end
    // Cycles since a move was taken
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) cnt_reg <= 4'h0;
        else if ((i_movx_rd || i_movx_wr) && !o_movx_busy) cnt_reg <= 4'h1;
        else if (o_movx_done) cnt_reg <= 4'h0;
        else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg + 4'h1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    stack_reset_a: assert property (disable iff (1'h0)
        i_rst |=> o_stack_ptr == 11'h007) else $error("stack not 07");
    push_step_a: assert property ((i_push && !i_pop && !i_dir_wr)
        |=> ##1 o_stack_ptr[7:0] == $past(o_stack_ptr[7:0]) + 8'h01)
        else $error("push did not step");
    stack_wrap_a: assert property (!ext_reg |->
        o_stack_ptr[10:8] == 3'h0) else $error("stack high bits set");
    movx_len_a: assert property (o_movx_done |->
        cnt_reg == 4'h4 + {1'h0, wait_reg}) else $error("move length");
    strobe_bus_a: assert property ((!o_ext_rd_n || !o_ext_wr_n)
        |-> o_ext_bus_en && o_movx_busy) else $error("stray strobe");
    latch_off_a: assert property (alo_reg |-> !o_latch_strobe)
        else $error("latch strobe while disabled");
    baud_follow_a: assert property ((i_dir_wr && i_addr == 8'h87)
        |=> ##1 o_baud_doubler == $past(i_wdata[7], 2))
        else $error("baud doubler wrong");
    sleep_entry_a: assert property ((i_dir_wr && i_addr == 8'h87
        && i_wdata[1]) |=> ##1 o_power_down) else $error("no sleep");
    prog_limit_a: assert property (i_prog_wr |=> o_prog_wr_ok ==
        ($past(i_prog_waddr) <= 16'hdfff)) else $error("prog limit");
    fetch_limit_a: assert property ((i_fetch_addr >= 16'hf800)
        |=> !o_fetch_internal) else $error("fetch above top");
endmodule // core_map_sva
bind core_memory_map_sfrs core_map_sva #(.PROG_AW(PROG_AW)) sva_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_dir_wr(i_dir_wr), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_push(i_push), .i_pop(i_pop),
    .i_movx_rd(i_movx_rd), .i_movx_wr(i_movx_wr),
    .i_fetch_addr(i_fetch_addr), .i_prog_wr(i_prog_wr),
    .i_prog_waddr(i_prog_waddr), .o_fetch_internal(o_fetch_internal),
    .o_prog_wr_ok(o_prog_wr_ok), .o_ext_bus_en(o_ext_bus_en),
    .o_ext_rd_n(o_ext_rd_n), .o_ext_wr_n(o_ext_wr_n),
    .o_latch_strobe(o_latch_strobe), .o_movx_done(o_movx_done),
    .o_movx_busy(o_movx_busy), .o_power_down(o_power_down),
    .o_baud_doubler(o_baud_doubler), .o_stack_ptr(o_stack_ptr));
`default_nettype wire

// [tb/ext_data_mem.sv]
// External data memory model on the parallel data bus
`timescale 1ns/1ps
`default_nettype none
module ext_data_mem (
    input wire logic i_clk,
    input wire logic [23:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_bus_en,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:255];
    logic [7:0] last = 8'h5a;
    // Store while write strobe is low
    always @(posedge i_clk) begin
        if (i_bus_en && !i_wr_n) mem[i_addr[7:0]] <= i_wdata;
        if (i_bus_en && !i_rd_n) last <= mem[i_addr[7:0]];
    end
    // Data only under read strobe, else inverse of last value
    assign o_rdata = (i_bus_en && !i_rd_n) ? mem[i_addr[7:0]] : ~last;
endmodule // ext_data_mem
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the core memory map block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic i_clk = 1'h0;
    logic i_rst = 1'h1;
    logic i_ext_access_pin = 1'h1;
    logic i_flag_wr = 1'h0;
    logic [7:0] i_flag_val = 8'h00;
    logic [7:0] i_prog_wdata = 8'h5a;
    logic [9:0] stb = 10'h000;
    logic i_dir_wr, i_dir_rd, i_ind_wr, i_ind_rd, i_reg_wr, i_bit_wr;
    logic i_bit_rd, i_push, i_pop, i_ptr_inc, i_bit_val, any_bus;
    logic i_movx_rd, i_movx_wr, i_prog_wr, i_serial_irq, i_irq0_n;
    logic i_irq0_edge_sel;
    logic [2:0] i_reg_num;
    logic [7:0] i_addr, i_wdata, i_bit_addr, i_stack_wdata, i_movx_wdata;
    logic [15:0] i_fetch_addr, i_prog_waddr;
    logic [7:0] o_rdata, o_movx_rdata, o_ext_wdata, i_ext_rdata;
    logic [23:0] o_ext_addr, seen_addr;
    logic o_fetch_internal, o_prog_wr_ok, o_ext_bus_en, o_ext_rd_n;
    logic o_ext_wr_n, o_latch_strobe, o_movx_done, o_movx_busy;
    logic o_power_down, o_baud_doubler;
    logic [1:0] o_bank_sel;
    logic [10:0] o_stack_ptr;
    int fails = 0, cmp_count = 0, cyc = 0, n, j;
    assign {i_pop, i_ptr_inc, i_push, i_bit_rd, i_bit_wr, i_reg_wr,
        i_ind_rd, i_ind_wr, i_dir_rd, i_dir_wr} = stb;
    core_memory_map_sfrs uut (.i_clk, .i_rst, .i_ext_access_pin, .i_dir_wr,
        .i_dir_rd, .i_ind_wr, .i_ind_rd, .i_addr, .i_wdata, .o_rdata,
        .i_reg_wr, .i_reg_num, .i_bit_wr, .i_bit_rd, .i_bit_addr, .i_bit_val,
        .i_push, .i_pop, .i_stack_wdata, .i_ptr_inc, .i_flag_wr, .i_flag_val,
        .i_fetch_addr, .i_prog_wr, .i_prog_waddr, .i_prog_wdata,
        .o_fetch_internal, .o_prog_wr_ok, .i_movx_rd, .i_movx_wr,
        .i_movx_wdata, .i_ext_rdata, .o_ext_addr, .o_ext_wdata, .o_ext_bus_en,
        .o_ext_rd_n, .o_ext_wr_n, .o_latch_strobe, .o_movx_rdata,
        .o_movx_done, .o_movx_busy, .i_serial_irq, .i_irq0_n, .i_irq0_edge_sel,
        .o_power_down, .o_baud_doubler, .o_bank_sel, .o_stack_ptr);
    ext_data_mem mem_model (.i_clk, .i_addr(o_ext_addr), .i_wdata(o_ext_wdata),
        .i_bus_en(o_ext_bus_en), .i_rd_n(o_ext_rd_n), .i_wr_n(o_ext_wr_n),
        .o_rdata(i_ext_rdata));
    // Clock and run ceiling
    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            summarize();
        end
    end
    task summarize;
        if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [23:0] s, input logic [23:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One strobe cycle, then an idle cycle
    task acc(input int k, input logic [7:0] a, input logic [7:0] d);
        {i_addr, i_bit_addr, i_wdata, i_stack_wdata} = {a, a, d, d};
        {i_reg_num, i_bit_val} = {a[2:0], d[0]};
        stb = 10'h001 << k;
        @(negedge i_clk);
        stb = 10'h000;
        @(negedge i_clk);
    endtask
    task rdc(input int k, input logic [7:0] a, input logic [7:0] e);
        acc(k, a, 8'h00);
        chk(o_rdata, e);
    endtask
    task ptr(input logic [23:0] p);
        acc(0, 8'h82, p[7:0]);
        acc(0, 8'h83, p[15:8]);
        acc(0, 8'h84, p[23:16]);
    endtask
    // Data move; n counts cycles from request cycle to done
    task mv(input logic w, input logic [7:0] d);
        {i_movx_wr, i_movx_rd, i_movx_wdata, any_bus} = {w, !w, d, 1'h0};
        @(negedge i_clk);
        {i_movx_wr, i_movx_rd} = 2'h0;
        for (n = 1; n < 20 && o_movx_done !== 1'h1; n++) begin
            @(negedge i_clk);
            if (o_ext_bus_en === 1'h1) {any_bus, seen_addr} = {1'h1, o_ext_addr};
        end
    endtask
    initial begin
        {i_movx_rd, i_movx_wr, i_prog_wr, i_serial_irq} = 4'h0;
        {i_irq0_edge_sel, i_irq0_n, i_movx_wdata} = {2'h1, 8'h00};
        {i_addr, i_bit_addr, i_wdata, i_stack_wdata, i_reg_num} = 35'h0;
        {i_fetch_addr, i_prog_waddr, i_bit_val} = 33'h0;
        repeat (6) @(negedge i_clk);
        i_rst = 1'h0;
        rdc(1, 8'h81, 8'h07);
        rdc(1, 8'h87, 8'h00);
        rdc(1, 8'h9f, 8'h00);
        rdc(1, 8'hd0, 8'h00);
        rdc(1, 8'haf, 8'h00);
        acc(0, 8'hb7, 8'h07);
        rdc(1, 8'hb7, 8'h00);
        acc(0, 8'h87, 8'h8d);
        rdc(1, 8'h87, 8'h8c);
        chk(o_baud_doubler, 1'h1);
        acc(0, 8'h9f, 8'hff);
        rdc(1, 8'h9f, 8'h07);
        acc(0, 8'haf, 8'h7e);
        rdc(1, 8'haf, 8'h00);
        for (j = 0; j < 4; j++) begin
            acc(0, 8'hd0, {3'h7, j[1:0], 3'h6});
            acc(4, 8'h02, 8'h40 + j[7:0]);
            rdc(1, {3'h0, j[1:0], 3'h2}, 8'h40 + j[7:0]);
            chk(o_bank_sel, j[1:0]);
        end
        acc(5, 8'hd5, 8'h00);
        rdc(1, 8'hd0, 8'hde);
        acc(0, 8'h21, 8'h00);
        acc(0, 8'h2f, 8'h00);
        acc(5, 8'h0b, 8'h01);
        acc(5, 8'h7f, 8'h01);
        rdc(1, 8'h21, 8'h08);
        rdc(1, 8'h2f, 8'h80);
        acc(6, 8'h0b, 8'h00);
        chk(o_rdata[0], 1'h1);
        acc(2, 8'h87, 8'h33);
        rdc(3, 8'h87, 8'h33);
        rdc(1, 8'h87, 8'h8c);
        acc(7, 8'h00, 8'h77);
        rdc(3, 8'h08, 8'h77);
        rdc(1, 8'h81, 8'h08);
        acc(9, 8'h00, 8'h00);
        rdc(1, 8'h81, 8'h07);
        acc(0, 8'h81, 8'hff);
        acc(7, 8'h00, 8'h99);
        rdc(1, 8'h81, 8'h00);
        rdc(3, 8'h00, 8'h99);
        acc(0, 8'haf, 8'h80);
        acc(0, 8'h81, 8'hff);
        acc(7, 8'h00, 8'h5a);
        chk(o_stack_ptr, 11'h100);
        rdc(1, 8'hb7, 8'h01);
        acc(0, 8'hb7, 8'h05);
        acc(0, 8'h81, 8'h10);
        chk(o_stack_ptr, 11'h510);
        acc(0, 8'haf, 8'h00);
        rdc(1, 8'hb7, 8'h00);
        for (j = 0; j < 2; j++) begin
            {i_prog_wr, i_fetch_addr} = {1'h1, 16'hf7ff + j[15:0]};
            i_prog_waddr = 16'hdfff + j[15:0];
            @(negedge i_clk);
            chk(o_fetch_internal, j == 0);
            chk(o_prog_wr_ok, j == 0);
        end
        i_prog_wr = 1'h0;
        ptr(24'h123456);
        for (j = 7; j >= 0; j -= 7) begin
            acc(0, 8'h9f, j[7:0]);
            acc(0, 8'h87, {3'h4, j == 0, 4'hc});
            mv(1'h1, 8'ha5 ^ j[7:0]);
            chk(n[23:0], 24'h4 + j[23:0]);
            chk(seen_addr, 24'h123456);
            mv(1'h0, 8'h00);
            chk(o_movx_rdata, 8'ha5 ^ j[7:0]);
        end
        ptr(24'h000010);
        mv(1'h0, 8'h00);
        chk(any_bus, 1'h1);
        acc(0, 8'haf, 8'h01);
        ptr(24'h0007ff);
        mv(1'h1, 8'h3c);
        chk(any_bus, 1'h0);
        mv(1'h0, 8'h00);
        chk(o_movx_rdata, 8'h3c);
        acc(8, 8'h00, 8'h00);
        mv(1'h0, 8'h00);
        chk(seen_addr, 24'h000800);
        ptr(24'h00ffff);
        acc(8, 8'h00, 8'h00);
        rdc(1, 8'h84, 8'h01);
        rdc(1, 8'h83, 8'h00);
        for (j = 0; j < 3; j++) begin
            i_irq0_edge_sel = j[0];
            acc(0, 8'h87, (j == 2) ? 8'h42 : 8'h22);
            chk(o_power_down, 1'h1);
            if (j == 2) i_serial_irq = 1'h1;
            else i_irq0_n = 1'h0;
            for (n = 0; n < 10 && o_power_down !== 1'h0; n++) @(negedge i_clk);
            chk(o_power_down, 1'h0);
            {i_serial_irq, i_irq0_n} = 2'h1;
            repeat (4) @(negedge i_clk);
        end
        summarize();
    end
endmodule // testbench
`default_nettype wire
